// >>> hdl/status_out_alloc.sv
// status output allocation: routes drive status onto six terminals
// assumes status inputs synchronous to CLK_I; a reset is the restart
// Behaviour
// - selection code zero routes the signal to no terminal.
// - codes one to six select terminals one to six.
// - each terminal has its own inversion bit, two words hold them.
// - inversion bits reset to zero and change only at restart.
// - alarm output closed when normal, open on any error.
// - three code bits show active alarm, optionally active warning.
// - code bits default to terminals four, five and six.
// - warning signal active while any warning condition exists.
// - warning signal has no default terminal.
// - warning code select: zero alarm only, one both; at restart.
// - alarm output stays closed while a warning code is shown.
// - rotary motor: rotation active at or above detection level.
// - linear motor compares against zero speed level instead.
// - rotation signal defaults to terminal pair two.
// - alarms stop operation, warnings only flag.
// - several signals on one terminal are ored together.
// - signals not evaluated in current mode count as off.
// - detection level 1 to 10000, default 20, effective at once.
`timescale 1ns/100ps
`default_nettype none
module status_out_alloc #(
  parameter int NSIG = status_out_pkg::NUM_SIG,
  parameter int NTERM = status_out_pkg::NUM_TERM
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // configuration words, captured once after restart
  input wire logic [status_out_pkg::WORD_W-1:0] ALLOCATION_WORD_E_I,
  input wire logic [status_out_pkg::WORD_W-1:0] ALLOCATION_WORD_F_I,
  input wire logic [11:0] ALARM_CODE_ALLOC_I,
  input wire logic [status_out_pkg::WORD_W-1:0] INVERSION_WORD_A_I,
  input wire logic [status_out_pkg::WORD_W-1:0] INVERSION_WORD_B_I,
  input wire logic [status_out_pkg::WORD_W-1:0] WARNING_CODE_SELECT_WORD_I,
  // live thresholds
  input wire logic [status_out_pkg::SPEED_W-1:0] ROTATION_DETECT_LEVEL_I,
  input wire logic [status_out_pkg::SPEED_W-1:0] LINEAR_ZERO_SPEED_LEVEL_I,
  input wire logic MOTOR_LINEAR_I,
  input wire logic [status_out_pkg::SPEED_W-1:0] SPEED_I,
  // drive status
  input wire logic [status_out_pkg::NUM_EXT-1:0] EXT_STATUS_I,
  input wire logic [NSIG-1:0] STATUS_VALID_I,
  input wire logic ALARM_ACTIVE_I,
  input wire logic [status_out_pkg::CODE_W-1:0] ALARM_CODE_I,
  input wire logic WARNING_ACTIVE_I,
  input wire logic [status_out_pkg::CODE_W-1:0] WARNING_CODE_I,
  // contact outputs, 1 = closed
  output logic [NTERM-1:0] TERM_O,
  output logic ALARM_OUT_O
);

  localparam int SW = status_out_pkg::SEL_W;
  localparam int NW = status_out_pkg::NIB_W;
  localparam int SIG_CODE_IDX0 = status_out_pkg::SIG_CODE0;

  logic cfg_loaded_q;
  logic [NSIG-1:0][SW-1:0] sel_q;
  logic [NTERM-1:0] inv_q;
  logic warn_sel_q;
  logic [NSIG-1:0] sig_d;
  logic [status_out_pkg::SPEED_W-1:0] level_d;
  logic [status_out_pkg::SPEED_W-1:0] level_raw;
  logic rotation_d;
  logic [status_out_pkg::CODE_W-1:0] code_d;

  // codes above six are not terminals and are treated as disabled
  function automatic logic [SW-1:0] nib_sel(input logic [NW-1:0] nib);
    if (nib > status_out_pkg::SEL_MAX) begin
      return status_out_pkg::SEL_NONE;
    end
    return nib[SW-1:0];
  endfunction

  // ***********************************************
  // configuration capture at restart
  // ***********************************************
  // one-shot capture: later port changes wait for the next reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_loaded_q <= 1'b0;
    end else begin
      cfg_loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < 4; i++) begin
        sel_q[i] <= nib_sel(status_out_pkg::ALLOC_E_RESET[i*NW +: NW]);
        sel_q[4+i] <= nib_sel(status_out_pkg::ALLOC_F_RESET[i*NW +: NW]);
      end
      for (int i = 0; i < 3; i++) begin
        sel_q[8+i] <= nib_sel(status_out_pkg::ALLOC_CODE_RESET[i*NW +: NW]);
      end
    end else if (!cfg_loaded_q) begin
      for (int i = 0; i < 4; i++) begin
        sel_q[i] <= nib_sel(ALLOCATION_WORD_E_I[i*NW +: NW]);
        sel_q[4+i] <= nib_sel(ALLOCATION_WORD_F_I[i*NW +: NW]);
      end
      for (int i = 0; i < 3; i++) begin
        sel_q[8+i] <= nib_sel(ALARM_CODE_ALLOC_I[i*NW +: NW]);
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      inv_q <= '0;
      warn_sel_q <= status_out_pkg::WARN_SEL_RESET;
    end else if (!cfg_loaded_q) begin
      for (int t = 0; t < 4; t++) begin
        inv_q[t] <= INVERSION_WORD_A_I[t*NW];
      end
      for (int t = 0; t < 2; t++) begin
        inv_q[4+t] <= INVERSION_WORD_B_I[t*NW];
      end
      warn_sel_q <= WARNING_CODE_SELECT_WORD_I[status_out_pkg::WARN_SEL_NIB*NW];
    end
  end

  // ***********************************************
  // rotation detection
  // ***********************************************
  assign level_raw = MOTOR_LINEAR_I ? LINEAR_ZERO_SPEED_LEVEL_I
                                    : ROTATION_DETECT_LEVEL_I;

  // out-of-range settings are clamped so a zero level never forces detection on
  always_comb begin
    level_d = level_raw;
    if (level_raw < status_out_pkg::LEVEL_MIN) begin
      level_d = status_out_pkg::LEVEL_MIN;
    end else if (level_raw > status_out_pkg::LEVEL_MAX) begin
      level_d = status_out_pkg::LEVEL_MAX;
    end
  end

  assign rotation_d = (SPEED_I >= level_d);

  // ***********************************************
  // code bits and status vector
  // ***********************************************
  always_comb begin
    code_d = '0;
    if (ALARM_ACTIVE_I) begin
      code_d = ALARM_CODE_I;
    end else if (warn_sel_q && WARNING_ACTIVE_I) begin
      code_d = WARNING_CODE_I;
    end
  end

  always_comb begin
    sig_d = '0;
    sig_d[status_out_pkg::SIG_POS_DONE] = EXT_STATUS_I[0];
    sig_d[status_out_pkg::SIG_SPEED_MATCH] = EXT_STATUS_I[1];
    sig_d[status_out_pkg::SIG_ROTATION] = rotation_d;
    sig_d[status_out_pkg::SIG_READY] = EXT_STATUS_I[2];
    sig_d[status_out_pkg::SIG_TORQUE_LIM] = EXT_STATUS_I[3];
    sig_d[status_out_pkg::SIG_SPEED_LIM] = EXT_STATUS_I[4];
    sig_d[status_out_pkg::SIG_BRAKE] = EXT_STATUS_I[5];
    sig_d[status_out_pkg::SIG_WARNING] = WARNING_ACTIVE_I;
    sig_d[status_out_pkg::SIG_CODE0] = code_d[0];
    sig_d[status_out_pkg::SIG_CODE1] = code_d[1];
    sig_d[status_out_pkg::SIG_CODE2] = code_d[2];
    sig_d = sig_d & STATUS_VALID_I;
  end

  // ***********************************************
  // terminals and alarm contact
  // ***********************************************
  for (genvar t = 0; t < NTERM; t++) begin : g_term
    output_slot #(
      .NSIG(NSIG),
      .SEL_W(SW),
      .TERM_CODE(SW'(t + 1))
    ) u_slot (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .sig_i(sig_d),
      .sel_i(sel_q),
      .invert_i(inv_q[t]),
      .term_o(TERM_O[t])
    );
  end

  // warnings never open the alarm contact
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ALARM_OUT_O <= 1'b0;
    end else begin
      ALARM_OUT_O <= !ALARM_ACTIVE_I;
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_alarm_opens: assert property (ALARM_ACTIVE_I |=> !ALARM_OUT_O)
    else $error("alarm contact not open during alarm");
  a_warn_keeps_closed: assert property (
    !ALARM_ACTIVE_I && WARNING_ACTIVE_I |=> ALARM_OUT_O)
    else $error("warning opened alarm contact");
  a_cfg_held_stable: assert property (cfg_loaded_q |=> $stable(inv_q) && $stable(sel_q)
      && $stable(warn_sel_q))
    else $error("configuration changed without restart");
  a_default_alloc: assert property (!cfg_loaded_q |-> sel_q[SIG_CODE_IDX0] == 3'h4
      && sel_q[SIG_CODE_IDX0+1] == 3'h5 && sel_q[SIG_CODE_IDX0+2] == 3'h6
      && sel_q[status_out_pkg::SIG_ROTATION] == status_out_pkg::SEL_TERM_PAIR2
      && sel_q[status_out_pkg::SIG_WARNING] == status_out_pkg::SEL_NONE
      && inv_q == '0)
    else $error("defaults after restart wrong");
  a_all_disabled: assert property (cfg_loaded_q && sel_q == '0 && inv_q == '0
      |=> TERM_O == '0)
    else $error("disabled signal reached a terminal");
  a_term1_or: assert property (cfg_loaded_q && !inv_q[0]
      && sel_q[status_out_pkg::SIG_POS_DONE] == 3'h1
      && sig_d[status_out_pkg::SIG_POS_DONE] |=> TERM_O[0])
    else $error("selected signal missing from terminal");
  a_code_alarm_only: assert property (cfg_loaded_q && !warn_sel_q && !ALARM_ACTIVE_I
      |-> code_d == '0)
    else $error("warning code shown while disabled");
  a_alarm_code_out: assert property (ALARM_ACTIVE_I |-> code_d == ALARM_CODE_I)
    else $error("alarm code not presented");
  a_rotation_level: assert property (!MOTOR_LINEAR_I
      && ROTATION_DETECT_LEVEL_I >= status_out_pkg::LEVEL_MIN
      && ROTATION_DETECT_LEVEL_I <= status_out_pkg::LEVEL_MAX
      |-> rotation_d == (SPEED_I >= ROTATION_DETECT_LEVEL_I))
    else $error("rotation compare wrong");
  a_linear_level: assert property (MOTOR_LINEAR_I
      && LINEAR_ZERO_SPEED_LEVEL_I >= status_out_pkg::LEVEL_MIN
      && LINEAR_ZERO_SPEED_LEVEL_I <= status_out_pkg::LEVEL_MAX
      |-> rotation_d == (SPEED_I >= LINEAR_ZERO_SPEED_LEVEL_I))
    else $error("zero speed compare wrong");
  a_invalid_off: assert property (cfg_loaded_q && STATUS_VALID_I == '0 && inv_q == '0
      |=> TERM_O == '0)
    else $error("unevaluated signal drove a terminal");

  c_alarm_seen: cover property (ALARM_ACTIVE_I ##1 !ALARM_OUT_O);
  c_warn_code: cover property (warn_sel_q && WARNING_ACTIVE_I && !ALARM_ACTIVE_I);
  c_rotation: cover property (rotation_d && MOTOR_LINEAR_I);
  c_inverted: cover property (cfg_loaded_q && inv_q != '0);

endmodule
`default_nettype wire

// >>> hdl/status_out_pkg.sv
// constants shared by the status output allocation block
// assumes one control clock; configuration words come in on plain ports
package status_out_pkg;

  // ***********************************************
  // sizes
  // ***********************************************
  localparam int NUM_TERM = 6;
  localparam int NUM_SIG = 11;
  localparam int SEL_W = 3;
  localparam int NIB_W = 4;
  localparam int WORD_W = 16;
  localparam int SPEED_W = 16;
  localparam int CODE_W = 3;

  // ***********************************************
  // status signal slots
  // ***********************************************
  localparam int SIG_POS_DONE = 0;
  localparam int SIG_SPEED_MATCH = 1;
  localparam int SIG_ROTATION = 2;
  localparam int SIG_READY = 3;
  localparam int SIG_TORQUE_LIM = 4;
  localparam int SIG_SPEED_LIM = 5;
  localparam int SIG_BRAKE = 6;
  localparam int SIG_WARNING = 7;
  localparam int SIG_CODE0 = 8;
  localparam int SIG_CODE1 = 9;
  localparam int SIG_CODE2 = 10;
  localparam int NUM_EXT = 6;

  // ***********************************************
  // selection codes
  // ***********************************************
  localparam logic [SEL_W-1:0] SEL_NONE = 3'h0;
  localparam logic [NIB_W-1:0] SEL_MAX = 4'h6;
  localparam logic [SEL_W-1:0] SEL_TERM_PAIR2 = 3'h2;

  // ***********************************************
  // reset values of the captured configuration
  // ***********************************************
  localparam logic [WORD_W-1:0] ALLOC_E_RESET = 16'h3200;
  localparam logic [WORD_W-1:0] ALLOC_F_RESET = 16'h0000;
  localparam logic [11:0] ALLOC_CODE_RESET = 12'h654;
  localparam logic [WORD_W-1:0] INV_A_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] INV_B_RESET = 16'h0000;
  localparam logic WARN_SEL_RESET = 1'b0;
  localparam int WARN_SEL_NIB = 3;

  // ***********************************************
  // speed threshold limits
  // ***********************************************
  localparam logic [SPEED_W-1:0] LEVEL_MIN = 16'h0001;
  localparam logic [SPEED_W-1:0] LEVEL_MAX = 16'h2710;
  localparam logic [SPEED_W-1:0] LEVEL_RESET = 16'h0014;

endpackage

// >>> hdl/output_slot.sv
// one output terminal: or of every status signal that selects it, then polarity
// assumes selection codes and polarity are already held stable by the caller
`timescale 1ns/100ps
`default_nettype none
module output_slot #(
  parameter int NSIG = 11,
  parameter int SEL_W = 3,
  parameter logic [SEL_W-1:0] TERM_CODE = 3'h1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // routing
  input wire logic [NSIG-1:0] sig_i,
  input wire logic [NSIG-1:0][SEL_W-1:0] sel_i,
  input wire logic invert_i,
  // terminal
  output logic term_o
);

  logic hit_d;

  always_comb begin
    hit_d = 1'b0;
    for (int i = 0; i < NSIG; i++) begin
      if (sel_i[i] == TERM_CODE && sig_i[i]) begin
        hit_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      term_o <= 1'b0;
    end else begin
      term_o <= hit_d ^ invert_i;
    end
  end

endmodule
`default_nettype wire

// >>> tb/host_relay_model.sv
// far side model: relay circuit that watches the alarm contact
// assumes contact outputs registered on the same control clock
`timescale 1ns/100ps
`default_nettype none
module host_relay_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // contact from the drive, 1 = closed
  input wire logic alarm_out_i,
  // main circuit contactor, 1 = power applied
  output logic main_power_o
);
  // ******************************
  // contactor
  // ******************************
  // one flop of relay delay; power stays off while the drive restarts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_power_o <= 1'b0;
    end else begin
      main_power_o <= alarm_out_i;
    end
  end
endmodule
`default_nettype wire

// >>> tb/status_output_allocation_bench.sv
// self-checking bench: random status and config across several restarts
// assumes outputs follow the inputs of the previous edge by one cycle
`timescale 1ns/100ps
`default_nettype none
module status_output_allocation_bench;
  // ******************************
  // signals
  // ******************************
  logic clk, rst, lin, alarm_out, wrn;
  logic [15:0] ae, af, inva, invb, wsel, rlvl, zlvl, spd;
  logic [15:0] ce, cf, cia, cib, cws;
  logic [11:0] ac, cac;
  logic [5:0] ext;
  logic [10:0] vld;
  logic [2:0] acode, wcode;
  wire logic [5:0] term;
  wire logic alm_out, power_on;
  int seed = 51;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;

  status_out_alloc dut (.CLK_I(clk), .RST_I(rst), .ALLOCATION_WORD_E_I(ae),
    .ALLOCATION_WORD_F_I(af), .ALARM_CODE_ALLOC_I(ac), .INVERSION_WORD_A_I(inva),
    .INVERSION_WORD_B_I(invb), .WARNING_CODE_SELECT_WORD_I(wsel),
    .ROTATION_DETECT_LEVEL_I(rlvl), .LINEAR_ZERO_SPEED_LEVEL_I(zlvl),
    .MOTOR_LINEAR_I(lin), .SPEED_I(spd), .EXT_STATUS_I(ext), .STATUS_VALID_I(vld),
    .ALARM_ACTIVE_I(alarm_out), .ALARM_CODE_I(acode), .WARNING_ACTIVE_I(wrn),
    .WARNING_CODE_I(wcode), .TERM_O(term), .ALARM_OUT_O(alm_out));

  host_relay_model u_host (.clk_i(clk), .rst_i(rst), .alarm_out_i(alm_out),
    .main_power_o(power_on));

  // ******************************
  // expectation and checking
  // ******************************
  function automatic logic [6:0] expect_out(input logic [15:0] e, f, ia, ib, ws,
                                            input logic [11:0] a);
    logic [43:0] w;
    logic [10:0] s;
    logic [15:0] lv;
    logic [5:0] t;
    logic [2:0] cd;
    lv = lin ? zlvl : rlvl;
    if (lv < status_out_pkg::LEVEL_MIN) lv = status_out_pkg::LEVEL_MIN;
    if (lv > status_out_pkg::LEVEL_MAX) lv = status_out_pkg::LEVEL_MAX;
    cd = alarm_out ? acode : ((ws[12] && wrn) ? wcode : 3'h0);
    s = {cd, wrn, ext[5:2], spd >= lv, ext[1:0]} & vld;
    w = {a, f, e};
    t = 6'h00;
    for (int i = 0; i < 11; i++) begin
      for (int k = 1; k <= 6; k++) begin
        if (s[i] && w[4*i +: 4] == 4'(k)) t[k-1] = 1'b1;
      end
    end
    t = t ^ {ib[4], ib[0], ia[12], ia[8], ia[4], ia[0]};
    return {!alarm_out, t};
  endfunction

  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ******************************
  // stimulus
  // ******************************
  // config words keep moving every cycle so late changes must be ignored
  task automatic drive_random();
    logic [31:0] r;
    r = $random(seed);
    ae = r[15:0] & 16'h7777;
    af = r[31:16] & 16'h7777;
    r = $random(seed);
    inva = r[15:0];
    invb = r[31:16];
    r = $random(seed);
    rlvl = {2'h0, r[13:0]};
    zlvl = {2'h0, r[29:16]};
    lin = r[30];
    wsel = {3'h0, r[31], 12'h000};
    r = $random(seed);
    ac = r[11:0] & 12'h777;
    ext = r[17:12];
    vld = r[31:21] | r[30:20];
    r = $random(seed);
    alarm_out = r[0] & r[1];
    wrn = r[2];
    acode = r[5:3];
    wcode = r[8:6];
    spd = r[9] ? (lin ? zlvl : rlvl) : {2'h0, r[29:16]};
  endtask

  task automatic run_restart(input int n, input int mode);
    logic [6:0] exp;
    logic prev;
    rst = 1'b1;
    #1;
    check({alm_out, term}, 7'h00);
    @(posedge clk);
    #1;
    rst = 1'b0;
    drive_random();
    if (mode == 1) begin
      // all but code bits 1 and 2 on terminal 1; those two get out-of-range codes that must disable
      ae = 16'h1111;
      af = 16'h1111;
      ac = 12'hf71;
      inva = 16'h1111;
      invb = 16'h0011;
      wsel = 16'h1000;
    end else if (mode == 2) begin
      // every signal disabled and no inversion: all terminals stay open
      ae = 16'h0000;
      af = 16'h0000;
      ac = 12'h000;
      inva = 16'h0000;
      invb = 16'h0000;
    end else if (mode == 3) begin
      // position done on terminal 1, no inversion; validity mask cleared on cycles where spd[1:0] is zero
      ae = (ae & 16'hfff0) | 16'h0001;
      inva = 16'h0000;
      invb = 16'h0000;
    end
    {ce, cf, cac, cia, cib, cws} = {ae, af, ac, inva, invb, wsel};
    exp = expect_out(status_out_pkg::ALLOC_E_RESET, status_out_pkg::ALLOC_F_RESET,
      status_out_pkg::INV_A_RESET, status_out_pkg::INV_B_RESET, 16'h0000,
      status_out_pkg::ALLOC_CODE_RESET);
    @(posedge clk);
    #1;
    check({alm_out, term}, exp);
    repeat (n) begin
      drive_random();
      if (mode == 3 && spd[1:0] == 2'h0) begin
        vld = '0;
      end
      exp = expect_out(ce, cf, cia, cib, cws, cac);
      prev = alm_out;
      @(posedge clk);
      #1;
      check({alm_out, term}, exp);
      check({alm_out, term}, exp);
      check({6'h00, power_on}, {6'h00, prev});
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    rst = 1'b1;
    {ae, af, ac, inva, invb, wsel, rlvl, zlvl, spd} = '0;
    {lin, alarm_out, wrn, ext, vld, acode, wcode} = '0;
    repeat (8) @(posedge clk);
    #1;
    run_restart(300, 1);
    run_restart(200, 2);
    run_restart(300, 3);
    for (int k = 0; k < 5; k++) begin
      run_restart(300, 0);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
